// file: logic/gpio_bank_pkg.sv
// Purpose: Shared constants and types for the three-port pin bank
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Offsets follow the port register map order
`default_nettype none
package gpio_bank_pkg;
    localparam logic [3:0] OFF_A_DATA = 4'h0;
    localparam logic [3:0] OFF_A_DIR  = 4'h1;
    localparam logic [3:0] OFF_A_OPT  = 4'h2;
    localparam logic [3:0] OFF_B_DATA = 4'h4;
    localparam logic [3:0] OFF_B_DIR  = 4'h5;
    localparam logic [3:0] OFF_B_OPT  = 4'h6;
    localparam logic [3:0] OFF_C_DATA = 4'h8;
    localparam logic [3:0] OFF_C_DIR  = 4'h9;
    localparam logic [3:0] OFF_C_OPT  = 4'ha;
    localparam logic [3:0] OFF_POL    = 4'hc;
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [1:0] RST_POL    = 2'b00;
    localparam int         POL1_LSB   = 2;
    localparam int         POL0_LSB   = 0;
    localparam int         NPINS      = 22;
    localparam int         PORTA_LSB  = 0;
    localparam int         PORTB_LSB  = 8;
    localparam int         PORTC_LSB  = 16;
    localparam int         PORTC_W    = 6;
    localparam logic [1:0] POL_FALL_LOW = 2'b00;
    localparam logic [1:0] POL_FALL     = 2'b10;
    localparam logic [1:0] POL_RISE     = 2'b01;
    localparam logic [1:0] POL_BOTH     = 2'b11;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } bus_req_type;

    typedef struct packed {
        logic [21:0] claim;
        logic [21:0] drive;
        logic [21:0] level;
        logic [21:0] push_pull;
    } alt_req_type;
endpackage : gpio_bank_pkg
`default_nettype wire

// file: logic/irq_line_detect.sv
// Purpose: Per-vector event detector with polarity field
// Assumes: Input already synchronised to clk_sys
// Notes:   Pending request clears on any polarity change
`timescale 1ns/1ps
`default_nettype none
module irq_line_detect (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       ce,
    // Combined pin level and polarity
    input  wire logic       level,
    input  wire logic       active,
    input  wire logic [1:0] polarity,
    input  wire logic       pol_changed,
    input  wire logic       ack,
    // Request to interrupt controller
    output logic            req
);
    logic prev_r;
    logic req_r;
    logic fell;
    logic rose;
    logic hit;

    assign fell = prev_r & ~level;
    assign rose = ~prev_r & level;
    assign hit  = active & ((polarity == gpio_bank_pkg::POL_FALL_LOW) ? ~level :
                            (polarity == gpio_bank_pkg::POL_FALL) ? fell :
                            (polarity == gpio_bank_pkg::POL_RISE) ? rose :
                            (fell | rose));

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prev_r <= 1'b1;
            req_r  <= 1'b0;
        end else if (ce) begin
            prev_r <= level;
            if (pol_changed) begin
                req_r <= 1'b0;
            end else if (hit) begin
                req_r <= 1'b1;
            end else if (ack) begin
                req_r <= 1'b0;
            end
        end
    end

    assign req = req_r;

    a_pol_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce && pol_changed |=> !req_r) else $error("request survived polarity change");
endmodule : irq_line_detect
`default_nettype wire

// file: logic/gpio_bank.sv
// Purpose: Three bidirectional pin ports with option, interrupt and alternate logic
// Assumes: One clock; pins synchronised by two flops; pad logic outside
// Notes:   Port A high option bit in output mode is reserved and treated as 0
`timescale 1ns/1ps
`default_nettype none
module gpio_bank #(
    parameter logic [21:0] VEC1_PINS = 22'h3fff00,
    parameter logic [21:0] HAS_OPT   = 22'h3fffff
) (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        resetn,
    input  wire logic                        ce,
    // Register port
    input  wire gpio_bank_pkg::bus_req_type  bus,
    output logic [7:0]                       rdata,
    // Pins
    input  wire logic [21:0]                 pin_in,
    output logic [21:0]                      pin_out,
    output logic [21:0]                      pin_oe,
    output logic [21:0]                      pull_up_en,
    // Peripherals
    input  wire gpio_bank_pkg::alt_req_type  alt,
    output logic [21:0]                      alt_in,
    // Interrupt controller
    input  wire logic [1:0]                  irq_ack,
    output logic [1:0]                       ext_irq_req
);
    localparam int N = gpio_bank_pkg::NPINS;

    initial begin
        if ((VEC1_PINS & ~HAS_OPT) != 22'h000000) begin
            $error("interrupt pins need option bits");
        end
    end

    logic [N-1:0] data_r;
    logic [N-1:0] dir_r;
    logic [N-1:0] opt_r;
    logic [3:0]   pol_r;
    logic [N-1:0] sync1_r;
    logic [N-1:0] sync2_r;
    logic [7:0]   rdata_r;
    logic [N-1:0] out_r;
    logic [N-1:0] oe_r;
    logic [N-1:0] pu_r;
    logic [N-1:0] alt_in_r;

    logic [N-1:0] opt_eff;
    logic [N-1:0] irq_en;
    logic [N-1:0] rd_view;
    logic [N-1:0] out_nxt;
    logic [N-1:0] oe_nxt;
    logic [N-1:0] pu_nxt;
    logic [N-1:0] wmask;
    logic [1:0]   vec_level;
    logic [1:0]   vec_active;
    logic [1:0]   req_w;
    logic [3:0]   pol_nxt;
    logic         pol_wr;
    logic [7:0]   rdata_nxt;
    logic [N-1:0] wbyte;

    // Byte lane mapping of write data across the 22 pins
    assign wbyte = {bus.wdata[gpio_bank_pkg::PORTC_W-1:0], bus.wdata, bus.wdata};
    assign wmask = (bus.addr[3:2] == 2'b00) ? 22'h0000ff :
                   (bus.addr[3:2] == 2'b01) ? 22'h00ff00 :
                   (bus.addr[3:2] == 2'b10) ? 22'h3f0000 : 22'h000000;

    // Configuration registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            data_r <= '0;
            dir_r  <= '0;
            opt_r  <= '0;
        end else if (ce && bus.wr) begin
            if (bus.addr[1:0] == 2'b00) begin
                data_r <= (data_r & ~wmask) | (wbyte & wmask);
            end
            if (bus.addr[1:0] == 2'b01) begin
                dir_r <= (dir_r & ~wmask) | (wbyte & wmask);
            end
            if (bus.addr[1:0] == 2'b10) begin
                opt_r <= (opt_r & ~wmask & HAS_OPT) | (wbyte & wmask & HAS_OPT);
            end
        end
    end

    // Polarity register
    assign pol_wr  = ce && bus.wr && (bus.addr == gpio_bank_pkg::OFF_POL);
    assign pol_nxt = bus.wdata[3:0];

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pol_r <= {gpio_bank_pkg::RST_POL, gpio_bank_pkg::RST_POL};
        end else if (pol_wr) begin
            pol_r <= pol_nxt;
        end
    end

    // Pin synchroniser
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= '1;
            sync2_r <= '1;
        end else if (ce) begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // Per-pin drive and interrupt enable
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            assign opt_eff[g] = HAS_OPT[g] & opt_r[g];
            assign irq_en[g]  = ~dir_r[g] & opt_eff[g] & ~alt.claim[g];
            assign rd_view[g] = (dir_r[g] & ~alt.claim[g]) ? data_r[g] : sync2_r[g];
            if (g < gpio_bank_pkg::PORTB_LSB) begin : g_a
                // True open drain only; reserved option treated as 0
                assign out_nxt[g] = 1'b0;
                assign oe_nxt[g]  = alt.claim[g] ? (alt.drive[g] & ~alt.level[g]) :
                                    (dir_r[g] & ~data_r[g]);
                assign pu_nxt[g]  = 1'b0;
            end else begin : g_bc
                assign out_nxt[g] = alt.claim[g] ? alt.level[g] : data_r[g];
                assign oe_nxt[g]  = alt.claim[g] ?
                                    (alt.drive[g] & (alt.push_pull[g] | ~alt.level[g])) :
                                    (dir_r[g] & (opt_eff[g] | ~data_r[g]));
                assign pu_nxt[g]  = ~alt.claim[g] & ~dir_r[g] & opt_eff[g];
            end
        end
    endgenerate

    // Vector combine: disabled pins read as 1 so they do not mask
    assign vec_level[0]  = &(sync2_r | ~(irq_en & ~VEC1_PINS));
    assign vec_level[1]  = &(sync2_r | ~(irq_en & VEC1_PINS));
    assign vec_active[0] = |(irq_en & ~VEC1_PINS);
    assign vec_active[1] = |(irq_en & VEC1_PINS);

    generate
        for (g = 0; g < 2; g++) begin : g_vec
            irq_line_detect u_det (
                .clk_sys     (clk_sys),
                .resetn      (resetn),
                .ce          (ce),
                .level       (vec_level[g]),
                .active      (vec_active[g]),
                .polarity    (pol_r[2*g+1:2*g]),
                .pol_changed (pol_wr && (pol_nxt[2*g+1:2*g] != pol_r[2*g+1:2*g])),
                .ack         (irq_ack[g]),
                .req         (req_w[g])
            );
        end
    endgenerate

    // Read mux
    assign rdata_nxt =
        (bus.addr == gpio_bank_pkg::OFF_A_DATA) ? rd_view[7:0] :
        (bus.addr == gpio_bank_pkg::OFF_A_DIR)  ? dir_r[7:0] :
        (bus.addr == gpio_bank_pkg::OFF_A_OPT)  ? opt_r[7:0] :
        (bus.addr == gpio_bank_pkg::OFF_B_DATA) ? rd_view[15:8] :
        (bus.addr == gpio_bank_pkg::OFF_B_DIR)  ? dir_r[15:8] :
        (bus.addr == gpio_bank_pkg::OFF_B_OPT)  ? opt_r[15:8] :
        (bus.addr == gpio_bank_pkg::OFF_C_DATA) ? {2'b00, rd_view[21:16]} :
        (bus.addr == gpio_bank_pkg::OFF_C_DIR)  ? {2'b00, dir_r[21:16]} :
        (bus.addr == gpio_bank_pkg::OFF_C_OPT)  ? {2'b00, opt_r[21:16]} :
        (bus.addr == gpio_bank_pkg::OFF_POL)    ? {4'h0, pol_r} : 8'h00;

    // Output registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_r  <= gpio_bank_pkg::RST_BYTE;
            out_r    <= '0;
            oe_r     <= '0;
            pu_r     <= '0;
            alt_in_r <= '1;
        end else if (ce) begin
            rdata_r  <= bus.rd ? rdata_nxt : 8'h00;
            out_r    <= out_nxt;
            oe_r     <= oe_nxt;
            pu_r     <= pu_nxt;
            alt_in_r <= sync2_r;
        end
    end

    assign rdata       = rdata_r;
    assign pin_out     = out_r;
    assign pin_oe      = oe_r;
    assign pull_up_en  = pu_r;
    assign alt_in      = alt_in_r;
    assign ext_irq_req = req_w;

    a_dir_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(resetn) |-> dir_r == '0) else $error("direction not zero");
    a_out_no_irq: assert property (@(posedge clk_sys) disable iff (!resetn)
        (dir_r & ~irq_en) == dir_r) else $error("output pin interrupt enabled");
    a_rd_latch: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce && bus.rd && bus.addr == gpio_bank_pkg::OFF_B_DATA && dir_r[15:8] == 8'hff
        && alt.claim[15:8] == 8'h00 |=> rdata_r == $past(data_r[15:8]))
        else $error("data read not latch");
    a_write_taken: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce && bus.wr && bus.addr == gpio_bank_pkg::OFF_A_DATA |=> data_r[7:0] == $past(bus.wdata))
        else $error("data write lost");
    a_alt_prio: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce && alt.claim[8] && alt.drive[8] && alt.push_pull[8] |=> oe_r[8])
        else $error("alternate drive ignored");
    a_alt_level: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce && alt.claim[9] |=> out_r[9] == $past(alt.level[9]))
        else $error("alternate level ignored");
    a_od_b: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce && !alt.claim[10] && dir_r[10] && !opt_r[10] && data_r[10] |=> !oe_r[10])
        else $error("open drain drove high");
    a_pa_od: assert property (@(posedge clk_sys) disable iff (!resetn)
        pin_out[7:0] == 8'h00) else $error("port a drove high");
    a_pullup: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce && !alt.claim[12] && !dir_r[12] && opt_r[12] |=> pu_r[12])
        else $error("pull-up missing");

    c_irq0: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(req_w[0]));
    c_irq1: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(req_w[1]));
    c_alt: cover property (@(posedge clk_sys) disable iff (!resetn) alt.claim != '0 && oe_r != '0);
    c_pol: cover property (@(posedge clk_sys) disable iff (!resetn) pol_wr);
endmodule : gpio_bank
`default_nettype wire

// file: testbench/pin_env.sv
// Purpose: Board-side model of the pins around the bank
// Assumes: External driver mask selects driven pins
// Notes:   Undriven pins follow pull-up or a toggling level
`timescale 1ns/1ps
`default_nettype none
module pin_env (
    // Clock
    input  wire logic        clk_sys,
    // Bank pad side
    input  wire logic [21:0] pin_out,
    input  wire logic [21:0] pin_oe,
    input  wire logic [21:0] pull_up_en,
    // Board drivers
    input  wire logic [21:0] ext,
    input  wire logic [21:0] ext_drv,
    // Resolved wire levels
    output logic      [21:0] pin_lvl
);
    logic [21:0] drift_r = 22'h000000;
    // Floating pins never hold a stable value
    always @(posedge clk_sys) drift_r <= ~drift_r;
    // Released pin falls to the board or the pull-up
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext)
                   | (~pin_oe & ~ext_drv & (pull_up_en | drift_r));
endmodule : pin_env
`default_nettype wire

// file: testbench/tb.sv
// Purpose: Self-checking bench for the three-port pin bank
// Assumes: Register model kept in bench integers
// Notes:   Clock enable held high throughout
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                       clk_sys;
    logic                       resetn;
    gpio_bank_pkg::bus_req_type bus;
    gpio_bank_pkg::alt_req_type alt;
    logic [7:0]                 rdata;
    logic [21:0]                pin_out, pin_oe, pull_up_en, alt_in, pin_lvl, ext, ext_drv;
    logic [1:0]                 irq_ack, ext_irq_req;
    int                         failures, n_compared, m, a;
    int                         mreg [16];

    gpio_bank gpio_bank_i (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .bus(bus),
        .rdata(rdata), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_en(pull_up_en), .alt(alt), .alt_in(alt_in), .irq_ack(irq_ack),
        .ext_irq_req(ext_irq_req));
    pin_env pin_env_i (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_en(pull_up_en), .ext(ext), .ext_drv(ext_drv), .pin_lvl(pin_lvl));

    task automatic complete_run();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk_byte

    task automatic chk_bit(input string n, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    function automatic int exp_rd(input int a);
        int p, v;
        p = a / 4;
        if (p > 2 || a % 4 == 3) return 0;
        if (a % 4 == 0) v = (mreg[a + 1] & mreg[a]) | (~mreg[a + 1] & int'(pin_lvl >> (8 * p)));
        else v = mreg[a];
        return (p == 2) ? (v & 8'h3f) : (v & 8'hff);
    endfunction : exp_rd

    task automatic wr(input int a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: 4'(a), wdata: d};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
        if (a != 12) mreg[a] = d;
    endtask : wr

    task automatic rd_chk(input int a);
        int e;
        e = exp_rd(a);
        @(posedge clk_sys);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: 4'(a), wdata: 8'h00};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 chk_byte("rdata", 8'(e), rdata);
    endtask : rd_chk

    task automatic settle();
        repeat (6) @(posedge clk_sys);
        #1;
    endtask : settle

    task automatic pin(input int i, input logic v);
        @(posedge clk_sys);
        ext[i] <= v;
        settle();
    endtask : pin

    task automatic ack();
        @(posedge clk_sys);
        irq_ack <= 2'b11;
        @(posedge clk_sys);
        irq_ack <= 2'b00;
        repeat (2) @(posedge clk_sys);
    endtask : ack

    task automatic chk_pins();
        int i, p, d, o, e;
        for (i = 0; i < 22; i++) begin
            p = i / 8;
            d = (mreg[4 * p] >> (i % 8)) & 1;
            o = (mreg[4 * p + 2] >> (i % 8)) & 1;
            if ((mreg[4 * p + 1] >> (i % 8)) & 1) e = (o == 1 && p > 0) ? d : (d & ext[i]);
            else e = ext[i];
            chk_bit("pin level", 1'(e), pin_lvl[i]);
        end
    endtask : chk_pins

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial begin
        #(50 * 30000);
        failures++;
        complete_run();
    end

    initial begin
        resetn = 1'b0;
        bus = '0;
        alt = '0;
        irq_ack = 2'b00;
        ext_drv = 22'h3fffff;
        failures = 0;
        n_compared = 0;
        foreach (mreg[i]) mreg[i] = 0;
        void'($urandom(32'h7d74c4aa));
        ext = 22'($urandom);
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        settle();
        for (a = 0; a < 16; a++) if (a != 12) rd_chk(a);
        repeat (3) begin
            @(posedge clk_sys);
            ext <= 22'($urandom);
            for (a = 0; a < 12; a += 4) begin
                wr(a, 8'($urandom));
                wr(a + 1, 8'($urandom));
                wr(a + 2, (a == 0) ? 8'($urandom) & ~8'(mreg[1]) : 8'($urandom));
            end
            settle();
            for (a = 0; a < 12; a++) rd_chk(a);
            chk_pins();
        end
        @(posedge clk_sys);
        ext <= 22'h3fffff;
        wr(1, 8'h00);
        wr(2, 8'h03);
        for (m = 0; m < 4; m++) begin
            pin(0, 1'b1);
            wr(12, 8'(m));
            ack();
            pin(0, 1'b0);
            chk_bit("irq fall", m != 1, ext_irq_req[0]);
            ack();
            pin(0, 1'b1);
            chk_bit("irq rise", m != 2, ext_irq_req[0]);
        end
        wr(12, 8'h02);
        ack();
        pin(1, 1'b0);
        ack();
        pin(0, 1'b0);
        chk_bit("irq masked", 1'b0, ext_irq_req[0]);
        pin(1, 1'b1);
        pin(0, 1'b1);
        pin(0, 1'b0);
        chk_bit("irq combined", 1'b1, ext_irq_req[0]);
        wr(12, 8'h03);
        settle();
        chk_bit("irq pol clear", 1'b0, ext_irq_req[0]);
        wr(1, 8'h01);
        ack();
        pin(0, 1'b1);
        pin(0, 1'b0);
        chk_bit("irq output pin", 1'b0, ext_irq_req[0]);
        wr(5, 8'hff);
        rd_chk(4);
        wr(5, 8'h00);
        wr(6, 8'h11);
        settle();
        chk_bit("pull up b", 1'b1, pull_up_en[8]);
        chk_bit("pull up b4", 1'b1, pull_up_en[12]);
        chk_bit("pull up a", 1'b0, pull_up_en[0]);
        wr(6, 8'h00);
        @(posedge clk_sys);
        alt <= '{claim: 22'h000300, drive: 22'h000100, level: 22'h000100,
                 push_pull: 22'h000100};
        settle();
        chk_bit("alt oe", 1'b1, pin_oe[8]);
        chk_bit("alt out", 1'b1, pin_out[8]);
        @(posedge clk_sys);
        alt.level <= 22'h000000;
        settle();
        chk_bit("alt low", 1'b0, pin_out[8]);
        @(posedge clk_sys);
        alt <= '{claim: 22'h000300, drive: 22'h000100, level: 22'h000100,
                 push_pull: 22'h000000};
        pin(9, 1'b0);
        chk_bit("alt od", 1'b0, pin_oe[8]);
        chk_bit("alt in", 1'b0, alt_in[9]);
        rd_chk(4);
        complete_run();
    end
endmodule : tb
`default_nettype wire
